// File: hdl/tcw_map.vh
// Purpose: Constants for one timer channel with pattern outputs
// Assumes: Byte offsets on a plain register port, 32-bit words
// Notes: Field positions refer to the channel mode register
`ifndef TCW_MAP_VH
`define TCW_MAP_VH
// Register byte offsets
`define TCW_OFS_CMD 8'h00
`define TCW_OFS_MODE 8'h04
`define TCW_OFS_CNT 8'h10
`define TCW_OFS_CMPA 8'h14
`define TCW_OFS_CMPB 8'h18
`define TCW_OFS_CMPC 8'h1C
`define TCW_OFS_STAT 8'h20
// Command register bits
`define TCW_CMD_ON 0
`define TCW_CMD_OFF 1
`define TCW_CMD_SWT 2
// Mode register fields (low bit positions)
`define TCW_F_CLKS 0
`define TCW_F_INV 3
`define TCW_F_GATE 4
`define TCW_F_CSTOP 6
`define TCW_F_CDIS 7
`define TCW_F_EEDG 8
`define TCW_F_ESEL 10
`define TCW_F_ETRG 12
`define TCW_F_PUD 13
`define TCW_F_PAUTO 14
`define TCW_F_WAVE 15
`define TCW_F_LDB 18
`define TCW_F_AMA 16
`define TCW_F_AMC 18
`define TCW_F_AEEV 20
`define TCW_F_ASWT 22
`define TCW_F_BMB 24
`define TCW_F_BMC 26
`define TCW_F_BEEV 28
`define TCW_F_BSWT 30
// Status register bits
`define TCW_S_OVF 0
`define TCW_S_LOVR 1
`define TCW_S_CPA 2
`define TCW_S_CPB 3
`define TCW_S_CPC 4
`define TCW_S_CLKON 16
`define TCW_S_LINEA 17
`define TCW_S_LINEB 18
// Line actions and edge choices
`define TCW_ACT_SET 2'h1
`define TCW_ACT_CLR 2'h2
`define TCW_ACT_TOG 2'h3
`define TCW_EDG_RISE 2'h1
`define TCW_EDG_FALL 2'h2
`define TCW_EDG_BOTH 2'h3
// Reset values and counter limit
`define TCW_RST_MODE 32'h0000_0000
`define TCW_RST_VAL 16'h0000
`define TCW_CNT_MAX 16'hFFFF
`endif

// File: hdl/tcw_edge.v
// Purpose: Rising and falling edge detector for one sampled level
// Assumes: Input is synchronous to core_clk
// Notes: Outputs are combinational pulses one clock long
module tcw_edge (
  input wire core_clk, // System clock
  input wire sys_rst, // Synchronous reset, active high
  input wire sig, // Level to watch
  output wire rise, // Pulse on a 0 to 1 change
  output wire fall // Pulse on a 1 to 0 change
);
  reg prev_ff;

  // Remember last level; track the pin in reset so release makes no edge
  always @(posedge core_clk) begin
    if (sys_rst) begin
      prev_ff <= sig;
    end else begin
      prev_ff <= sig;
    end
  end

  // Compare present and past level
  assign rise = sig & ~prev_ff;
  assign fall = ~sig & prev_ff;
endmodule // tcw_edge

// File: hdl/tcw_channel.v
// Purpose: One 16-bit timer channel with pattern lines and status flags
// Assumes: All pins synchronous to core_clk; register read data next cycle
// Notes: Counter clock is an enable derived from sampled clock edges
//
// Chosen here: the address-and-strobe port and the register offsets.
`include "tcw_map.vh"
module tcw_channel (
  input wire core_clk, // System clock, 50 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata, // Read data, cycle after strobe
  input wire internal_clock_1, // Internal count clock 1
  input wire internal_clock_2, // Internal count clock 2
  input wire internal_clock_3, // Internal count clock 3
  input wire internal_clock_4, // Internal count clock 4
  input wire internal_clock_5, // Internal count clock 5
  input wire ext_clock_0, // External clock 0
  input wire ext_clock_1, // External clock 1
  input wire ext_clock_2, // External clock 2
  input wire timer_line_a_in, // Line A pin level
  output wire timer_line_a_out, // Line A drive value
  output wire timer_line_a_oe, // Line A drive enable
  input wire timer_line_b_in, // Line B pin level
  output wire timer_line_b_out, // Line B drive value
  output wire timer_line_b_oe // Line B drive enable
);
  reg [31:0] mode_ff;
  reg [15:0] cnt_ff;
  reg [15:0] cmpa_ff;
  reg [15:0] cmpb_ff;
  reg [15:0] cmpc_ff;
  reg dir_down_ff;
  reg clk_on_ff;
  reg run_ff;
  reg line_a_ff;
  reg line_b_ff;
  reg ovf_ff;
  reg lovr_ff;
  reg cpa_ff;
  reg cpb_ff;
  reg cpc_ff;
  reg b_unread_ff;
  reg [15:0] nxt_cnt;
  reg nxt_dir_down;
  reg nxt_line_a;
  reg nxt_line_b;
  reg sel_clk;
  reg gate_lvl;
  reg ev_src;
  reg [31:0] nxt_rdata;
  reg wrap_ev;

  wire wave;
  wire wr_cmd;
  wire rd_stat;
  wire sw_trig;
  wire clk_rise;
  wire ev_rise;
  wire ev_fall;
  wire la_rise;
  wire la_fall;
  wire tick;
  wire ext_ev;
  wire b_is_input;
  wire auto_trig;
  wire up_down;
  wire match_a;
  wire match_b;
  wire match_c;
  wire trig;
  wire load_b;
  wire turn_pt;
  wire [15:0] turn_val;

  // Pick an edge from a 2-bit code: none, rise, fall, each
  function edge_hit;
    input [1:0] code;
    input r;
    input f;
    begin
      case (code)
        `TCW_EDG_RISE: edge_hit = r;
        `TCW_EDG_FALL: edge_hit = f;
        `TCW_EDG_BOTH: edge_hit = r | f;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Apply one action code to a line level
  function act_apply;
    input cur;
    input [1:0] act;
    begin
      case (act)
        `TCW_ACT_SET: act_apply = 1'b1;
        `TCW_ACT_CLR: act_apply = 1'b0;
        `TCW_ACT_TOG: act_apply = ~cur;
        default: act_apply = cur;
      endcase
    end
  endfunction

  // Highest event wins: soft trigger, external event, compare C, own compare
  function line_next;
    input cur;
    input e_sw;
    input [1:0] a_sw;
    input e_ev;
    input [1:0] a_ev;
    input e_c;
    input [1:0] a_c;
    input e_x;
    input [1:0] a_x;
    begin
      if (e_sw) begin
        line_next = act_apply(cur, a_sw);
      end else if (e_ev) begin
        line_next = act_apply(cur, a_ev);
      end else if (e_c) begin
        line_next = act_apply(cur, a_c);
      end else if (e_x) begin
        line_next = act_apply(cur, a_x);
      end else begin
        line_next = cur;
      end
    end
  endfunction

  // Decoded mode and bus strobes
  assign wave = mode_ff[`TCW_F_WAVE];
  assign wr_cmd = reg_wr & (reg_addr == `TCW_OFS_CMD);
  assign rd_stat = reg_rd & (reg_addr == `TCW_OFS_STAT);
  assign sw_trig = wr_cmd & reg_wdata[`TCW_CMD_SWT];
  assign auto_trig = wave & mode_ff[`TCW_F_PAUTO];
  assign up_down = wave & mode_ff[`TCW_F_PUD];
  assign b_is_input = (mode_ff[`TCW_F_ESEL +: 2] == 2'h0);

  // Count clock source and external gate
  always @* begin
    case (mode_ff[`TCW_F_CLKS +: 3])
      3'h0: sel_clk = internal_clock_1;
      3'h1: sel_clk = internal_clock_2;
      3'h2: sel_clk = internal_clock_3;
      3'h3: sel_clk = internal_clock_4;
      3'h4: sel_clk = internal_clock_5;
      3'h5: sel_clk = ext_clock_0;
      3'h6: sel_clk = ext_clock_1;
      default: sel_clk = ext_clock_2;
    endcase
    case (mode_ff[`TCW_F_GATE +: 2])
      2'h1: gate_lvl = ext_clock_0;
      2'h2: gate_lvl = ext_clock_1;
      2'h3: gate_lvl = ext_clock_2;
      default: gate_lvl = 1'b1;
    endcase
    case (mode_ff[`TCW_F_ESEL +: 2])
      2'h1: ev_src = ext_clock_0;
      2'h2: ev_src = ext_clock_1;
      2'h3: ev_src = ext_clock_2;
      default: ev_src = timer_line_b_in;
    endcase
  end

  // Edge of gated count clock; invert turns a fall into a rise
  tcw_edge u_clk_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sig((sel_clk & gate_lvl) ^ mode_ff[`TCW_F_INV]),
    .rise(clk_rise),
    .fall()
  );

  // Edges of external event source
  tcw_edge u_ev_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sig(ev_src),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  // Edges of line A pin for capture loads
  tcw_edge u_la_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sig(timer_line_a_in),
    .rise(la_rise),
    .fall(la_fall)
  );

  // Events seen this cycle
  assign tick = clk_on_ff & run_ff & clk_rise;
  assign ext_ev = wave &
    edge_hit(mode_ff[`TCW_F_EEDG +: 2], ev_rise, ev_fall);
  assign match_a = tick & (cnt_ff == cmpa_ff);
  assign match_b = tick & (cnt_ff == cmpb_ff);
  assign match_c = tick & (cnt_ff == cmpc_ff);
  assign load_b = ~wave &
    edge_hit(mode_ff[`TCW_F_LDB +: 2], la_rise, la_fall);
  assign trig = sw_trig |
    (ext_ev & mode_ff[`TCW_F_ETRG]);
  assign turn_val = auto_trig ? cmpc_ff : `TCW_CNT_MAX;
  assign turn_pt = cnt_ff == turn_val;

  // Next count, direction and overflow
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_dir_down = dir_down_ff;
    wrap_ev = 1'b0;
    if (trig) begin
      nxt_cnt = `TCW_RST_VAL;
      nxt_dir_down = 1'b0;
    end else if (tick) begin
      if (up_down) begin
        if (!dir_down_ff && turn_pt) begin
          nxt_dir_down = 1'b1;
          nxt_cnt = cnt_ff - 16'h0001;
        end else if (dir_down_ff && cnt_ff == `TCW_RST_VAL) begin
          nxt_dir_down = 1'b0;
          nxt_cnt = 16'h0001;
        end else if (dir_down_ff) begin
          nxt_cnt = cnt_ff - 16'h0001;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end else if (auto_trig && match_c) begin
        nxt_cnt = `TCW_RST_VAL;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
        wrap_ev = (cnt_ff == `TCW_CNT_MAX);
      end
    end
  end

  // Counter and clock state
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_ff <= `TCW_RST_VAL;
      dir_down_ff <= 1'b0;
      clk_on_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      dir_down_ff <= nxt_dir_down;
      if (wr_cmd && reg_wdata[`TCW_CMD_OFF]) begin
        clk_on_ff <= 1'b0;
      end else if (match_c && wave && mode_ff[`TCW_F_CDIS]) begin
        clk_on_ff <= 1'b0;
      end else if (wr_cmd && reg_wdata[`TCW_CMD_ON]) begin
        clk_on_ff <= 1'b1;
      end
      if (trig) begin
        run_ff <= 1'b1;
      end else if (match_c && wave && mode_ff[`TCW_F_CSTOP]) begin
        run_ff <= 1'b0;
      end
    end
  end

  // Pattern line levels
  always @* begin
    nxt_line_a = line_next(line_a_ff,
      sw_trig, mode_ff[`TCW_F_ASWT +: 2],
      ext_ev, mode_ff[`TCW_F_AEEV +: 2],
      match_c, mode_ff[`TCW_F_AMC +: 2],
      match_a, mode_ff[`TCW_F_AMA +: 2]);
    nxt_line_b = line_next(line_b_ff,
      sw_trig, mode_ff[`TCW_F_BSWT +: 2],
      ext_ev, mode_ff[`TCW_F_BEEV +: 2],
      match_c, mode_ff[`TCW_F_BMC +: 2],
      match_b, mode_ff[`TCW_F_BMB +: 2]);
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      line_a_ff <= 1'b0;
      line_b_ff <= 1'b0;
    end else begin
      if (wave) begin
        line_a_ff <= nxt_line_a;
      end
      if (wave && !b_is_input) begin
        line_b_ff <= nxt_line_b;
      end
    end
  end

  // Line drivers; line B turns input when chosen as event source
  assign timer_line_a_out = line_a_ff;
  assign timer_line_a_oe = wave;
  assign timer_line_b_out = line_b_ff;
  assign timer_line_b_oe = wave & ~b_is_input;

  // Mode and compare registers
  always @(posedge core_clk) begin
    if (sys_rst) begin
      mode_ff <= `TCW_RST_MODE;
      cmpa_ff <= `TCW_RST_VAL;
      cmpb_ff <= `TCW_RST_VAL;
      cmpc_ff <= `TCW_RST_VAL;
    end else begin
      if (reg_wr && reg_addr == `TCW_OFS_MODE) begin
        mode_ff <= reg_wdata;
      end
      if (reg_wr && wave && reg_addr == `TCW_OFS_CMPA) begin
        cmpa_ff <= reg_wdata[15:0];
      end
      if (load_b) begin
        cmpb_ff <= cnt_ff;
      end else if (reg_wr && wave && reg_addr == `TCW_OFS_CMPB) begin
        cmpb_ff <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `TCW_OFS_CMPC) begin
        cmpc_ff <= reg_wdata[15:0];
      end
    end
  end

  // Sticky flags; a new event wins over the clearing read
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ovf_ff <= 1'b0;
      lovr_ff <= 1'b0;
      cpa_ff <= 1'b0;
      cpb_ff <= 1'b0;
      cpc_ff <= 1'b0;
      b_unread_ff <= 1'b0;
    end else begin
      ovf_ff <= wrap_ev | (ovf_ff & ~rd_stat);
      lovr_ff <= (load_b & b_unread_ff) | (lovr_ff & ~rd_stat);
      cpa_ff <= (match_a & wave) | (cpa_ff & ~rd_stat);
      cpb_ff <= (match_b & wave & ~b_is_input) |
        (cpb_ff & ~rd_stat);
      cpc_ff <= match_c | (cpc_ff & ~rd_stat);
      if (load_b) begin
        b_unread_ff <= 1'b1;
      end else if (reg_rd && reg_addr == `TCW_OFS_CMPB) begin
        b_unread_ff <= 1'b0;
      end
    end
  end

  // Read multiplexer; unmapped and write-only offsets read zero
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      `TCW_OFS_MODE: nxt_rdata = mode_ff;
      `TCW_OFS_CNT: nxt_rdata[15:0] = cnt_ff;
      `TCW_OFS_CMPA: nxt_rdata[15:0] = cmpa_ff;
      `TCW_OFS_CMPB: nxt_rdata[15:0] = cmpb_ff;
      `TCW_OFS_CMPC: nxt_rdata[15:0] = cmpc_ff;
      `TCW_OFS_STAT: begin
        nxt_rdata[`TCW_S_OVF] = ovf_ff;
        nxt_rdata[`TCW_S_LOVR] = lovr_ff & ~wave;
        nxt_rdata[`TCW_S_CPA] = cpa_ff & wave;
        nxt_rdata[`TCW_S_CPB] = cpb_ff & wave;
        nxt_rdata[`TCW_S_CPC] = cpc_ff;
        nxt_rdata[`TCW_S_CLKON] = clk_on_ff;
        nxt_rdata[`TCW_S_LINEA] = wave ? line_a_ff : timer_line_a_in;
        nxt_rdata[`TCW_S_LINEB] = timer_line_b_oe ? line_b_ff :
          timer_line_b_in;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data register, valid only the cycle after a read strobe
  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // tcw_channel

// File: tb/tcw_chk.sv
// Purpose: Port checks for the timer channel
// Assumes: One clock, synchronous active-high reset
// Notes: Shadows mirror the register writes the block accepts
`include "tcw_map.vh"
module tcw_chk (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic timer_line_a_oe, // Line A enable
  input wire logic timer_line_b_oe // Line B enable
);
  logic [31:0] mode_ff;
  logic [15:0] cmpa_ff;
  logic [15:0] cmpc_ff;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Shadows of mode and compare values
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_ff <= 32'h0;
      cmpa_ff <= 16'h0;
      cmpc_ff <= 16'h0;
    end else if (reg_wr) begin
      if (reg_addr == `TCW_OFS_MODE) begin
        mode_ff <= reg_wdata;
      end
      if (reg_addr == `TCW_OFS_CMPA && mode_ff[15]) begin
        cmpa_ff <= reg_wdata[15:0];
      end
      if (reg_addr == `TCW_OFS_CMPC) begin
        cmpc_ff <= reg_wdata[15:0];
      end
    end
  end
  a_line_a_oe: assert property (timer_line_a_oe == mode_ff[15])
    else $error("line A enable differs from mode");
  a_line_b_oe: assert property (
    timer_line_b_oe == (mode_ff[15] && mode_ff[11:10] != 2'h0))
    else $error("line B enable differs from event select");
  a_upper_zero: assert property (
    reg_rd && reg_addr[7:4] == 4'h1 |=> reg_rdata[31:16] == 16'h0)
    else $error("upper value bits not zero");
  a_cmpa_back: assert property (
    reg_rd && reg_addr == `TCW_OFS_CMPA |=> reg_rdata == {16'h0, cmpa_ff})
    else $error("compare A readback wrong");
  a_cmpc_back: assert property (
    reg_rd && reg_addr == `TCW_OFS_CMPC |=> reg_rdata == {16'h0, cmpc_ff})
    else $error("compare C readback wrong");
  a_flags_capt: assert property (
    reg_rd && reg_addr == `TCW_OFS_STAT && !mode_ff[15]
    |=> reg_rdata[3:2] == 2'h0)
    else $error("compare A or B flag set in capture");
  a_ovr_wave: assert property (
    reg_rd && reg_addr == `TCW_OFS_STAT && mode_ff[15]
    |=> !reg_rdata[1])
    else $error("overrun flag set in pattern mode");
  a_trig_zero: assert property (
    reg_wr && reg_addr == `TCW_OFS_CMD && reg_wdata[2]
    ##2 reg_rd && reg_addr == `TCW_OFS_CNT |=> reg_rdata[15:2] == 14'h0)
    else $error("counter not zeroed by soft trigger");
endmodule // tcw_chk
bind tcw_channel tcw_chk tcw_chk_i (.core_clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_line_a_oe,
  .timer_line_b_oe);

// File: tb/tcw_far.sv
// Purpose: Far side: clock lines and timer pin levels
// Assumes: Pulse requests last one cycle
// Notes: A requested clock line stays high for eight cycles
module tcw_far (
  input wire logic core_clk, // Clock
  input wire logic [7:0] pulse, // Requests: 0-4 internal, 5-7 external
  input wire logic a_lvl, // Line A level when released
  input wire logic a_out, // Line A drive value
  input wire logic a_oe, // Line A drive enable
  input wire logic b_out, // Line B drive value
  input wire logic b_oe, // Line B drive enable
  output logic [7:0] clk_lines, // Clock line levels
  output logic a_in, // Resolved line A
  output logic b_in // Resolved line B, pulled low when released
);
  logic [31:0] cnt_ff = 32'h0;
  // Each clock line counts down its high time in its own nibble
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pulse[i]) begin
        cnt_ff[4*i +: 4] <= 4'h8;
      end else if (cnt_ff[4*i +: 4] != 4'h0) begin
        cnt_ff[4*i +: 4] <= cnt_ff[4*i +: 4] - 4'h1;
      end
    end
  end
  // Line levels from all drivers
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      clk_lines[i] = (cnt_ff[4*i +: 4] != 4'h0);
    end
    a_in = a_oe ? a_out : a_lvl;
    b_in = b_oe ? b_out : 1'b0;
  end
endmodule // tcw_far

// File: tb/tb_top.sv
// Purpose: Register-level tests of the timer channel
// Assumes: Partner makes clock pulses on request
// Notes: Each tick costs fifteen cycles
`include "tcw_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] pulse = 8'h00;
  logic a_lvl = 1'b0;
  logic [31:0] v;
  logic ok;
  logic [7:0] ad [7] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h08};
  wire [31:0] reg_rdata;
  wire [7:0] cl;
  wire a_in, a_out, a_oe, b_in, b_out, b_oe;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 core_clk = ~core_clk;
  tcw_channel tcw_channel_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_clock_1(cl[0]),
    .internal_clock_2(cl[1]), .internal_clock_3(cl[2]),
    .internal_clock_4(cl[3]), .internal_clock_5(cl[4]),
    .ext_clock_0(cl[5]), .ext_clock_1(cl[6]), .ext_clock_2(cl[7]),
    .timer_line_a_in(a_in), .timer_line_a_out(a_out),
    .timer_line_a_oe(a_oe), .timer_line_b_in(b_in),
    .timer_line_b_out(b_out), .timer_line_b_oe(b_oe));
  tcw_far tcw_far_i (.core_clk(core_clk), .pulse(pulse), .a_lvl(a_lvl),
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .clk_lines(cl), .a_in(a_in), .b_in(b_in));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    rd(a);
    chk(v & m, e);
  endtask
  // Mode write, settle, then clock on with soft trigger
  task automatic go(input logic [31:0] m);
    wr(`TCW_OFS_MODE, m);
    repeat (3) @(posedge core_clk);
    wr(`TCW_OFS_CMD, 32'h5);
  endtask
  task automatic pls(input logic [7:0] m);
    pulse <= m;
    @(posedge core_clk);
    pulse <= 8'h00;
    repeat (14) @(posedge core_clk);
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    foreach (ad[j]) rc(ad[j], 32'hFFFF_FFFF, 32'h0);
    wr(`TCW_OFS_CMPA, 32'h1234);
    rc(`TCW_OFS_CMPA, 32'hFFFF_FFFF, 32'h0);
    wr(`TCW_OFS_CMPC, 32'h5);
    rc(`TCW_OFS_CMPC, 32'hFFFF_FFFF, 32'h5);
    wr(`TCW_OFS_CNT, 32'h77);
    rc(`TCW_OFS_CNT, 32'hFFFF_FFFF, 32'h0);
    for (int i = 0; i < 8; i++) begin
      go(32'h0000_8000 + 32'(i));
      pls(8'h01 << i);
      pls(8'h01 << ((i + 1) % 8));
      rc(`TCW_OFS_CNT, 32'hFFFF, 32'h1);
    end
    for (int k = 0; k < 2; k++) begin
      go(32'h0000_8000 + 32'(k * 8));
      pulse <= 8'h01;
      @(posedge core_clk);
      pulse <= 8'h00;
      repeat (3) @(posedge core_clk);
      rc(`TCW_OFS_CNT, 32'hFFFF, 32'(1 - k));
      repeat (10) @(posedge core_clk);
      rc(`TCW_OFS_CNT, 32'hFFFF, 32'h1);
    end
    for (int g = 1; g < 4; g++) begin
      go(32'h0000_8000 + 32'(g * 16));
      pls(8'h01);
      rc(`TCW_OFS_CNT, 32'hFFFF, 32'h0);
      pls(8'h01 | (8'h10 << g));
      rc(`TCW_OFS_CNT, 32'hFFFF, 32'h1);
    end
    go(32'h0309_8400);
    wr(`TCW_OFS_CMPA, 32'h1);
    wr(`TCW_OFS_CMPB, 32'h1);
    wr(`TCW_OFS_CMPC, 32'h3);
    rc(`TCW_OFS_CMPA, 32'hFFFF_FFFF, 32'h1);
    repeat (2) pls(8'h01);
    rc(`TCW_OFS_STAT, 32'h7_001F, 32'h7_000C);
    chk({31'h0, a_out}, 32'h1);
    rc(`TCW_OFS_STAT, 32'h1F, 32'h0);
    repeat (2) pls(8'h01);
    rc(`TCW_OFS_STAT, 32'h2_001F, 32'h10);
    rc(`TCW_OFS_STAT, 32'h1F, 32'h0);
    for (int k = 0; k < 3; k++) begin
      go(32'h0000_8000 + ((k == 0) ? 32'h0 : (32'h20 << k)));
      repeat (6) pls(8'h01);
      rd(`TCW_OFS_CNT);
      ok = (k == 0) ? (v == 32'h6) : (v == 32'h4);
      chk({31'h0, ok}, 32'h1);
      rc(`TCW_OFS_STAT, 32'h1_0000, (k == 2) ? 32'h0 : 32'h1_0000);
    end
    // Auto trigger wraps at compare C; up-down turns back there
    for (int m = 0; m < 2; m++) begin
      go(32'h0000_C000 + 32'(m * 8192));
      repeat (4) pls(8'h01);
      rc(`TCW_OFS_CNT, 32'hFFFF, (m == 0) ? 32'h0 : 32'h2);
    end
    for (int e = 0; e < 4; e++) begin
      go(32'h0030_9400 + 32'(e * 256));
      repeat (2) pls(8'h01);
      pls(8'h20);
      rc(`TCW_OFS_CNT, 32'hFFFF, (e == 0) ? 32'h2 : 32'h0);
      rc(`TCW_OFS_STAT, 32'h2_0000, (e == 1) ? 32'h2_0000 : 32'h0);
    end
    wr(`TCW_OFS_MODE, 32'h4040_8400);
    pls(8'h01);
    wr(`TCW_OFS_CMD, 32'h4);
    rc(`TCW_OFS_CNT, 32'hFFFF, 32'h0);
    rc(`TCW_OFS_STAT, 32'h6_0000, 32'h6_0000);
    chk({31'h0, b_out}, 32'h1);
    chk({31'h0, b_oe}, 32'h1);
    wr(`TCW_OFS_MODE, 32'h4040_8000);
    chk({31'h0, b_oe}, 32'h0);
    wr(`TCW_OFS_CMD, 32'h3);
    rc(`TCW_OFS_STAT, 32'h1_0000, 32'h0);
    wr(`TCW_OFS_CMD, 32'h1);
    rc(`TCW_OFS_STAT, 32'h1_0000, 32'h1_0000);
    wr(`TCW_OFS_CMD, 32'h2);
    rc(`TCW_OFS_STAT, 32'h1_0000, 32'h0);
    a_lvl <= 1'b1;
    go(32'h000C_0000);
    repeat (2) pls(8'h01);
    a_lvl <= 1'b0;
    repeat (4) @(posedge core_clk);
    a_lvl <= 1'b1;
    repeat (4) @(posedge core_clk);
    rc(`TCW_OFS_CMPB, 32'hFFFF, 32'h2);
    rc(`TCW_OFS_STAT, 32'h2, 32'h2);
    rc(`TCW_OFS_STAT, 32'h1E, 32'h0);
    end_of_test();
  end
endmodule // tb_top
